// file: include/pmi_defs.vh
// Constants for the PHY management register block with indirect MMD access.
// Assumes inclusion by bare name from the design files.
`ifndef PMI_DEFS_VH
`define PMI_DEFS_VH
// ----------------------------------------------------------------------------
// Direct register indices
// ----------------------------------------------------------------------------
`define PMI_IDX_MMD_CTRL 5'h0d
`define PMI_IDX_MMD_DATA 5'h0e
`define PMI_IDX_SPECIAL 5'h1f
// ----------------------------------------------------------------------------
// Special control/status fields
// ----------------------------------------------------------------------------
`define PMI_SPC_FIXED_RST 7'h02
`define PMI_SPC_DONE_BIT 12
`define PMI_SPC_FIX_HI 11
`define PMI_SPC_FIX_LO 5
`define PMI_SPD_10HD 3'h1
`define PMI_SPD_100HD 3'h2
`define PMI_SPD_10FD 3'h5
`define PMI_SPD_100FD 3'h6
// ----------------------------------------------------------------------------
// Access control fields
// ----------------------------------------------------------------------------
`define PMI_FN_HI 15
`define PMI_FN_LO 14
`define PMI_FN_ADDR 2'h0
`define PMI_FN_DATA 2'h1
`define PMI_DEV_HI 4
`define PMI_DEV_LO 0
`define PMI_DEV_PCS 5'h03
`define PMI_DEV_AN 5'h07
`define PMI_DEV_VEND 5'h1e
// ----------------------------------------------------------------------------
// MMD register indices
// ----------------------------------------------------------------------------
`define PMI_MIDX_ID1 16'h0002
`define PMI_MIDX_ID2 16'h0003
`define PMI_MIDX_PRES1 16'h0005
`define PMI_MIDX_PRES2 16'h0006
`define PMI_MIDX_STAT 16'h0008
`define PMI_MIDX_PKG1 16'h000e
`define PMI_MIDX_PKG2 16'h000f
`define PMI_MIDX_WUCSR 16'h8010
`define PMI_MIDX_WUFA 16'h8011
`define PMI_MIDX_WUFB 16'h8012
`define PMI_MIDX_MASK0 16'h8021
`define PMI_MIDX_MASK7 16'h8028
`define PMI_MIDX_RXA 16'h8061
`define PMI_MIDX_RXC 16'h8063
// ----------------------------------------------------------------------------
// Storage slots of the MMD memory
// ----------------------------------------------------------------------------
`define PMI_SLOT_WUCSR 4'h0
`define PMI_SLOT_WUFA 4'h1
`define PMI_SLOT_WUFB 4'h2
`define PMI_SLOT_MASK0 4'h3
`define PMI_SLOT_RXA 4'hb
// ----------------------------------------------------------------------------
// Constant MMD contents
// ----------------------------------------------------------------------------
`define PMI_PCS_PRES1 16'h0088
`define PMI_PCS_PRES2 16'h4000
`define PMI_ZERO16 16'h0000
`endif

// file: src/pmi_mem.v
// Small register memory holding the writable MMD registers.
// Assumes one clock and an active-low asynchronous reset; read data is registered.
`timescale 1ns/10ps
module pmi_mem (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Write port
    input wire wrEn,
    input wire [3:0] wrAddr,
    input wire [15:0] wrData,
    // Read port
    input wire [3:0] rdAddr,
    output reg [15:0] rdData
);
    reg [15:0] store [0:15];
    integer i;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < 16; i = i + 1) begin
                store[i] <= 16'h0000;
            end
            rdData <= 16'h0000;
        end else begin
            if (wrEn) begin
                store[wrAddr] <= wrData;
            end
            rdData <= (wrEn && wrAddr == rdAddr) ? wrData : store[rdAddr];
        end
    end
endmodule // pmi_mem

// file: src/pmi_decode.v
// Decoder from MMD device address and index to a register selection.
// Assumes purely combinational use by the top module.
`timescale 1ns/10ps
`include "pmi_defs.vh"
module pmi_decode (
    // Pointer
    input wire [4:0] device,
    input wire [15:0] index,
    // Selection
    output reg hit,
    output reg stored,
    output reg [3:0] slot,
    output reg [15:0] constVal
);
    // The vendor identity values are arbitrary neutral values.
    parameter [15:0] VEND_ID1 = 16'h1234;
    parameter [15:0] VEND_ID2 = 16'h5678;
    parameter [15:0] VEND_PKG1 = 16'h0000;
    parameter [15:0] VEND_PKG2 = 16'h0000;
    parameter [15:0] VEND_STAT = 16'h0000;

    wire [15:0] maskOff = index - `PMI_MIDX_MASK0;
    wire [15:0] rxOff = index - `PMI_MIDX_RXA;

    always @* begin
        hit = 1'b0;
        stored = 1'b0;
        slot = 4'h0;
        constVal = `PMI_ZERO16;
        case (device)
            `PMI_DEV_PCS: begin
                if (index == `PMI_MIDX_PRES1) begin
                    hit = 1'b1;
                    constVal = `PMI_PCS_PRES1;
                end else if (index == `PMI_MIDX_PRES2) begin
                    hit = 1'b1;
                    constVal = `PMI_PCS_PRES2;
                end else if (index == `PMI_MIDX_WUCSR) begin
                    hit = 1'b1;
                    stored = 1'b1;
                    slot = `PMI_SLOT_WUCSR;
                end else if (index == `PMI_MIDX_WUFA) begin
                    hit = 1'b1;
                    stored = 1'b1;
                    slot = `PMI_SLOT_WUFA;
                end else if (index == `PMI_MIDX_WUFB) begin
                    hit = 1'b1;
                    stored = 1'b1;
                    slot = `PMI_SLOT_WUFB;
                end else if (index >= `PMI_MIDX_MASK0 && index <= `PMI_MIDX_MASK7) begin
                    hit = 1'b1;
                    stored = 1'b1;
                    slot = `PMI_SLOT_MASK0 + maskOff[3:0];
                end else if (index >= `PMI_MIDX_RXA && index <= `PMI_MIDX_RXC) begin
                    hit = 1'b1;
                    stored = 1'b1;
                    slot = `PMI_SLOT_RXA + rxOff[3:0];
                end
            end
            `PMI_DEV_AN: begin
                if (index == `PMI_MIDX_PRES1) begin
                    hit = 1'b1;
                    constVal = `PMI_PCS_PRES1;
                end else if (index == `PMI_MIDX_PRES2) begin
                    hit = 1'b1;
                    constVal = `PMI_PCS_PRES2;
                end
            end
            `PMI_DEV_VEND: begin
                hit = 1'b1;
                case (index)
                    `PMI_MIDX_ID1: constVal = VEND_ID1;
                    `PMI_MIDX_ID2: constVal = VEND_ID2;
                    `PMI_MIDX_PRES1: constVal = `PMI_PCS_PRES1;
                    `PMI_MIDX_PRES2: constVal = `PMI_PCS_PRES2;
                    `PMI_MIDX_STAT: constVal = VEND_STAT;
                    `PMI_MIDX_PKG1: constVal = VEND_PKG1;
                    `PMI_MIDX_PKG2: constVal = VEND_PKG2;
                    default: hit = 1'b0;
                endcase
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end
endmodule // pmi_decode

// file: src/pmi_top.v
// PHY management registers: special control/status and indirect MMD access.
// Assumes a synchronous register port: one-cycle read or write strobes with index.
`timescale 1ns/10ps
`include "pmi_defs.vh"
module pmi_top (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Register port
    input wire regWrite,
    input wire regRead,
    input wire [4:0] regIndex,
    input wire [15:0] regWrData,
    output reg [15:0] regRdData,
    output reg regRdValid,
    // PHY status inputs
    input wire autonegDone,
    input wire [2:0] linkSpeed,
    // Observed state
    output reg [4:0] mmdDevice,
    output reg [15:0] mmdPointer,
    output reg mmdDataPhase
);
    // ------------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------------
    reg [15:0] accessCtrl;
    reg [6:0] specialFixed;
    reg [2:0] speedField;
    reg doneFlag;
    reg pendRead;
    reg [4:0] pendIndex;
    reg pendMmd;
    reg [15:0] pendConst;
    reg pendStored;
    reg pendHit;

    wire decHit;
    wire decStored;
    wire [3:0] decSlot;
    wire [15:0] decConst;
    wire [15:0] memRd;

    function isSpeedCode;
        input [2:0] code;
        begin
            isSpeedCode = (code == `PMI_SPD_10HD) || (code == `PMI_SPD_100HD) ||
                (code == `PMI_SPD_10FD) || (code == `PMI_SPD_100FD);
        end
    endfunction

    wire isDataWrite = regWrite && regIndex == `PMI_IDX_MMD_DATA;
    wire isDataRead = regRead && regIndex == `PMI_IDX_MMD_DATA;
    wire memWrite = isDataWrite && mmdDataPhase && decHit && decStored;

    // ------------------------------------------------------------------------
    // Decoder and storage
    // ------------------------------------------------------------------------
    pmi_decode uDecode (
        .device(mmdDevice),
        .index(mmdPointer),
        .hit(decHit),
        .stored(decStored),
        .slot(decSlot),
        .constVal(decConst)
    );

    pmi_mem uMem (
        .clock(clock),
        .rstn(rstn),
        .wrEn(memWrite),
        .wrAddr(decSlot),
        .wrData(regWrData),
        .rdAddr(decSlot),
        .rdData(memRd)
    );

    // ------------------------------------------------------------------------
    // Status sampling and register writes
    // ------------------------------------------------------------------------
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            doneFlag <= 1'b0;
            speedField <= 3'h0;
            specialFixed <= `PMI_SPC_FIXED_RST;
            accessCtrl <= 16'h0000;
            mmdDevice <= 5'h00;
            mmdPointer <= 16'h0000;
            mmdDataPhase <= 1'b0;
        end else begin
            doneFlag <= autonegDone;
            speedField <= isSpeedCode(linkSpeed) ? linkSpeed : 3'h0;
            if (regWrite && regIndex == `PMI_IDX_SPECIAL) begin
                specialFixed <= regWrData[`PMI_SPC_FIX_HI:`PMI_SPC_FIX_LO];
            end
            if (regWrite && regIndex == `PMI_IDX_MMD_CTRL) begin
                accessCtrl <= regWrData;
                mmdDevice <= regWrData[`PMI_DEV_HI:`PMI_DEV_LO];
                mmdDataPhase <= regWrData[`PMI_FN_HI:`PMI_FN_LO] == `PMI_FN_DATA;
            end
            if (isDataWrite && !mmdDataPhase) begin
                mmdPointer <= regWrData;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pendRead <= 1'b0;
            pendIndex <= 5'h00;
            pendMmd <= 1'b0;
            pendConst <= 16'h0000;
            pendStored <= 1'b0;
            pendHit <= 1'b0;
        end else begin
            pendRead <= regRead;
            pendIndex <= regIndex;
            pendMmd <= isDataRead && mmdDataPhase;
            pendConst <= decConst;
            pendStored <= decStored;
            pendHit <= decHit;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= pendRead;
            if (pendRead) begin
                case (pendIndex)
                    `PMI_IDX_SPECIAL: begin
                        regRdData <= {3'h0, doneFlag, specialFixed, speedField, 2'h0};
                    end
                    `PMI_IDX_MMD_CTRL: begin
                        regRdData <= accessCtrl;
                    end
                    `PMI_IDX_MMD_DATA: begin
                        if (!pendMmd) begin
                            regRdData <= mmdPointer;
                        end else if (!pendHit) begin
                            regRdData <= `PMI_ZERO16;
                        end else begin
                            regRdData <= pendStored ? memRd : pendConst;
                        end
                    end
                    default: begin
                        regRdData <= 16'h0000;
                    end
                endcase
            end
        end
    end
endmodule // pmi_top

// file: testbench/pmi_checker.sv
// Assertion checker for the PHY management register block.
// Assumes binding to pmi_top; read answers arrive two edges after the strobe.
`timescale 1ns/10ps
module pmi_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regIndex,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid,
    // Status and state
    input wire logic autonegDone,
    input wire logic [2:0] linkSpeed,
    input wire logic [4:0] mmdDevice,
    input wire logic [15:0] mmdPointer,
    input wire logic mmdDataPhase
);
    logic [15:0] lastWr;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lastWr <= 16'h0000;
        end else begin
            lastWr <= regWrData;
        end
    end
    sequence s_spcRead;
        regRead && regIndex == 5'h1f;
    endsequence
    sequence s_steady;
        ($stable(linkSpeed) && $stable(autonegDone))[*3] ##0 s_spcRead
            ##1 ($stable(linkSpeed) && $stable(autonegDone));
    endsequence
    property p_readLatency;
        regRead |-> ##2 regRdValid;
    endproperty
    property p_frame;
        s_spcRead |-> ##2 (regRdData[15:13] == 3'h0 && regRdData[1:0] == 2'h0);
    endproperty
    property p_doneHi;
        s_steady ##0 autonegDone |-> ##1 regRdData[12];
    endproperty
    property p_doneLo;
        s_steady ##0 !autonegDone |-> ##1 !regRdData[12];
    endproperty
    // The answer reflects the speed sampled at the read edge, so compare with the held value.
    property p_speed;
        s_steady |-> ##1
            regRdData[4:2] == (($past(linkSpeed) inside {3'h1, 3'h2, 3'h5, 3'h6}) ?
            $past(linkSpeed) : 3'h0);
    endproperty
    property p_unmapped;
        regRead && !(regIndex inside {5'h0d, 5'h0e, 5'h1f}) |-> ##2 regRdData == 16'h0000;
    endproperty
    property p_device;
        regWrite && regIndex == 5'h0d |=>
            mmdDevice == lastWr[4:0] && mmdDataPhase == (lastWr[15:14] == 2'h1);
    endproperty
    property p_pointer;
        regWrite && regIndex == 5'h0e && !mmdDataPhase |=> mmdPointer == lastWr;
    endproperty
    property p_ptrHold;
        regWrite && regIndex == 5'h0e && mmdDataPhase |=> $stable(mmdPointer);
    endproperty
    a_readLatency: assert property (p_readLatency) else $error("read answer late");
    a_frame: assert property (p_frame) else $error("special frame bits set");
    a_doneHi: assert property (p_doneHi) else $error("done bit low");
    a_doneLo: assert property (p_doneLo) else $error("done bit high");
    a_speed: assert property (p_speed) else $error("speed field wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped index data");
    a_device: assert property (p_device) else $error("access control not taken");
    a_pointer: assert property (p_pointer) else $error("pointer not loaded");
    a_ptrHold: assert property (p_ptrHold) else $error("pointer moved");
endmodule // pmi_checker
bind pmi_top pmi_checker pmi_checker_i (.clock(clock), .rstn(rstn), .regWrite(regWrite),
    .regRead(regRead), .regIndex(regIndex), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .autonegDone(autonegDone), .linkSpeed(linkSpeed),
    .mmdDevice(mmdDevice), .mmdPointer(mmdPointer), .mmdDataPhase(mmdDataPhase));

// file: testbench/pmi_phy_model.sv
// Model of the PHY status source: negotiation state and resolved speed.
// Assumes the bench requests a state; outputs change only on clock edges.
`timescale 1ns/10ps
module pmi_phy_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Requested link state
    input wire logic reqDone,
    input wire logic [2:0] reqSpeed,
    // Status toward the block
    output logic autonegDone,
    output logic [2:0] linkSpeed
);
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            autonegDone <= 1'b0;
            linkSpeed <= 3'h0;
        end else begin
            autonegDone <= reqDone;
            linkSpeed <= reqSpeed;
        end
    end
endmodule // pmi_phy_model

// file: testbench/pmi_top_tb_top.sv
// Self-checking bench for the PHY management register block.
// Assumes pmi_top, its header and the PHY status model are compiled alongside.
`timescale 1ns/10ps
`include "pmi_defs.vh"
module pmi_top_tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [4:0] regIndex = 5'h00;
    logic [15:0] regWrData = 16'h0000;
    logic reqDone = 1'b0;
    logic [2:0] reqSpeed = 3'h0;
    wire [15:0] regRdData;
    wire regRdValid;
    wire autonegDone;
    wire [2:0] linkSpeed;
    wire [4:0] mmdDevice;
    wire [15:0] mmdPointer;
    wire mmdDataPhase;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [15:0] pcsIdx [8] = '{16'h8010, 16'h8011, 16'h8012, 16'h8021, 16'h8024,
        16'h8028, 16'h8061, 16'h8063};
    // Device, index, expected value; all are written with ones before the read.
    logic [39:0] roTab [14] = '{40'h03_0005_0088, 40'h03_0006_4000, 40'h07_0005_0088,
        40'h07_0006_4000, 40'h1e_0002_1234, 40'h1e_0003_5678, 40'h1e_0005_0088,
        40'h1e_0006_4000, 40'h1e_0008_0000, 40'h1e_000e_0000, 40'h1e_000f_0000,
        40'h03_0007_0000, 40'h01_0005_0000, 40'h07_0008_0000};
    always #2 clock = ~clock;
    pmi_phy_model pmi_phy_model_i (.clock(clock), .rstn(rstn), .reqDone(reqDone),
        .reqSpeed(reqSpeed), .autonegDone(autonegDone), .linkSpeed(linkSpeed));
    pmi_top pmi_top_i (.clock(clock), .rstn(rstn), .regWrite(regWrite), .regRead(regRead),
        .regIndex(regIndex), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .autonegDone(autonegDone), .linkSpeed(linkSpeed),
        .mmdDevice(mmdDevice), .mmdPointer(mmdPointer), .mmdDataPhase(mmdDataPhase));
    // ------------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regIndex <= idx;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
        int n;
        @(posedge clock);
        regRead <= 1'b1;
        regIndex <= idx;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        for (n = 0; n < 4 && regRdValid !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        chk((regRdValid === 1'b1) ? regRdData : 16'hdead, exp);
    endtask
    task automatic sel(input logic [4:0] dev, input logic [15:0] idx);
        wr(`PMI_IDX_MMD_CTRL, {2'h0, 9'h000, dev});
        wr(`PMI_IDX_MMD_DATA, idx);
        wr(`PMI_IDX_MMD_CTRL, {2'h1, 9'h000, dev});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        rd(`PMI_IDX_SPECIAL, 16'h0040);
        for (int s = 0; s < 8; s++) begin
            @(posedge clock);
            reqDone <= s[0];
            reqSpeed <= s[2:0];
            repeat (4) @(posedge clock);
            rd(`PMI_IDX_SPECIAL, {3'h0, s[0], 7'h02,
                (s inside {1, 2, 5, 6}) ? s[2:0] : 3'h0, 2'h0});
        end
        // Fixed bits are written with their required pattern; ones aimed at the speed bits must not stick, and the done bit reads its status.
        wr(`PMI_IDX_SPECIAL, 16'h105c);
        rd(`PMI_IDX_SPECIAL, 16'h1040);
        wr(`PMI_IDX_SPECIAL, 16'h0040);
        rd(`PMI_IDX_SPECIAL, 16'h1040);
        rd(5'h00, 16'h0000);
        $display("test special register done");
        foreach (pcsIdx[k]) begin
            sel(`PMI_DEV_PCS, pcsIdx[k]);
            wr(`PMI_IDX_MMD_DATA, 16'(16'h1111 * (k + 1)));
        end
        foreach (pcsIdx[k]) begin
            sel(`PMI_DEV_PCS, pcsIdx[k]);
            rd(`PMI_IDX_MMD_DATA, 16'(16'h1111 * (k + 1)));
        end
        $display("test stored registers done");
        foreach (roTab[k]) begin
            sel(roTab[k][36:32], roTab[k][31:16]);
            wr(`PMI_IDX_MMD_DATA, 16'hffff);
            rd(`PMI_IDX_MMD_DATA, roTab[k][15:0]);
        end
        $display("test constant registers done");
        // Back in the address phase the data register shows the last pointer, 0x0008.
        wr(`PMI_IDX_MMD_CTRL, {2'h0, 9'h000, `PMI_DEV_PCS});
        rd(`PMI_IDX_MMD_CTRL, 16'h0003);
        rd(`PMI_IDX_MMD_DATA, 16'h0008);
        $display("test address phase done");
        end_of_test();
    end
    initial begin
        #40000;
        n_mismatch++;
        end_of_test();
    end
endmodule // pmi_top_tb_top
